/* hdl/dtr_timer_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Dual timer: run control, overflow flags, gating and count registers
module dtr_timer_top (
   // Clock and reset
   input  wire logic       CLOCK_I,
   input  wire logic       RESETN_I,
   // Byte access port
   input  wire logic [7:0] SFR_ADDR_I,
   input  wire logic       SFR_WR_I,
   input  wire logic [7:0] SFR_WDATA_I,
   input  wire logic       SFR_RD_I,
   output var  logic [7:0] SFR_RDATA_O,
   // Bit access port
   input  wire logic       BIT_WR_I,
   input  wire logic [7:0] BIT_ADDR_I,
   input  wire logic       BIT_VAL_I,
   // External pins
   input  wire logic       EXT_IRQ0_INPUT_I,
   input  wire logic       EXT_IRQ1_INPUT_I,
   input  wire logic       T0_COUNT_PIN_I,
   input  wire logic       T1_COUNT_PIN_I,
   // Overflow flags
   output var  logic       T0_OVERFLOW_FLAG_O,
   output var  logic       T1_OVERFLOW_FLAG_O
);
   // ==========================================================================
   // Declarations
   logic [7:0]  ctl_q, ctl_d;
   logic [7:0]  mcfg_q, mcfg_d;
   logic [7:0]  lo0_q, lo0_d, hi0_q, hi0_d;
   logic [7:0]  tl1_q, tl1_d, th1_q, th1_d;
   logic [7:0]  rdata_d;
   logic [3:0]  div_q, div_d;
   logic [1:0]  cpin_prev_q, cpin_prev_d;
   logic [3:0]  pin_lvl;
   logic        irq0_lvl, irq1_lvl;
   logic [1:0]  cpin_fall;
   logic        tick;
   logic [1:0]  m0, m1;
   logic        split;
   logic        src0, src1;
   logic        en_t0, en_hi0, en_t1;
   logic        ovf0, ovf1;
   logic [16:0] s0, s1;
   logic        wr_tcs, wr_tmc, wr_t0, wr_t1;
   logic        bit_hit;
   logic [7:0]  bit_mask;
   logic [15:0] cnt0, cnt1;

   // ==========================================================================
   // Pin synchronisers
   dtr_pin_sync #(
      .W(4)
   ) u_sync (
      .clk_i  (CLOCK_I),
      .rst_n_i(RESETN_I),
      .pin_i  ({T1_COUNT_PIN_I, T0_COUNT_PIN_I, EXT_IRQ1_INPUT_I, EXT_IRQ0_INPUT_I}),
      .level_o(pin_lvl)
   );

   // Level and edge views of the synchronised pins
   assign irq0_lvl  = pin_lvl[0];
   assign irq1_lvl  = pin_lvl[1];
   assign cpin_fall = cpin_prev_q & ~pin_lvl[3:2];

   // ==========================================================================
   // Instruction-cycle prescaler
   // Free-running, one tick every twelve clocks
   always_comb begin
      tick        = (div_q == dtr_pkg::TICK_LAST);
      div_d       = tick ? 4'h0 : 4'(div_q + 4'h1);
      cpin_prev_d = pin_lvl[3:2];
   end

   // ==========================================================================
   // Mode decode and count enables
   // Nibble fields of the mode register
   always_comb begin
      m0     = mcfg_q[1:0];
      m1     = mcfg_q[dtr_pkg::T1_NIB+1:dtr_pkg::T1_NIB];
      split  = (m0 == dtr_pkg::MODE_SPLIT);
      src0   = mcfg_q[dtr_pkg::CT_BIT] ? cpin_fall[0] : tick;
      src1   = mcfg_q[dtr_pkg::T1_NIB+dtr_pkg::CT_BIT] ? cpin_fall[1] : tick;
      // Run bit, and interrupt level when gated
      en_t0  = ctl_q[dtr_pkg::T0_RUN] && src0 &&
               (!mcfg_q[dtr_pkg::GATE_BIT] || irq0_lvl);
      // Split high byte borrows the timer 1 run bit
      en_hi0 = split && ctl_q[dtr_pkg::T1_RUN] && tick;
      // Timer 1 halts in mode 11, and free-runs while timer 0 is split
      en_t1  = (m1 != dtr_pkg::MODE_SPLIT) && src1 &&
               (split || (ctl_q[dtr_pkg::T1_RUN] &&
               (!mcfg_q[dtr_pkg::T1_NIB+dtr_pkg::GATE_BIT] || irq1_lvl)));
      s0     = dtr_pkg::step(m0, hi0_q, lo0_q);
      s1     = dtr_pkg::step(m1, th1_q, tl1_q);
   end

   // ==========================================================================
   // Register decode
   always_comb begin
      wr_tcs   = SFR_WR_I && (SFR_ADDR_I == dtr_pkg::ADDR_TCS);
      wr_tmc   = SFR_WR_I && (SFR_ADDR_I == dtr_pkg::ADDR_TMC);
      wr_t0    = SFR_WR_I && ((SFR_ADDR_I == dtr_pkg::ADDR_T0L) ||
                              (SFR_ADDR_I == dtr_pkg::ADDR_T0H));
      wr_t1    = SFR_WR_I && ((SFR_ADDR_I == dtr_pkg::ADDR_T1L) ||
                              (SFR_ADDR_I == dtr_pkg::ADDR_T1H));
      bit_hit  = BIT_WR_I && (BIT_ADDR_I[7:3] == dtr_pkg::BIT_BLOCK);
      bit_mask = 8'h01 << BIT_ADDR_I[2:0];
      cnt0     = {hi0_q, lo0_q};
      cnt1     = {th1_q, tl1_q};
   end

   // ==========================================================================
   // Counters, flags and register writes
   // Count step first, software write wins over the step
   always_comb begin
      lo0_d = lo0_q;
      hi0_d = hi0_q;
      tl1_d = tl1_q;
      th1_d = th1_q;
      ovf0  = 1'b0;
      ovf1  = 1'b0;
      if (en_t0) begin
         {ovf0, hi0_d, lo0_d} = s0;
      end
      if (en_hi0) begin
         hi0_d = 8'(hi0_q + 8'h01);
         ovf1  = &hi0_q;
      end
      if (en_t1) begin
         {th1_d, tl1_d} = s1[15:0];
         ovf1 = ovf1 || (!split && s1[16]);
      end
      if (wr_t0 && SFR_ADDR_I == dtr_pkg::ADDR_T0L) begin
         lo0_d = SFR_WDATA_I;
      end
      if (wr_t0 && SFR_ADDR_I == dtr_pkg::ADDR_T0H) begin
         hi0_d = SFR_WDATA_I;
      end
      if (wr_t1 && SFR_ADDR_I == dtr_pkg::ADDR_T1L) begin
         tl1_d = SFR_WDATA_I;
      end
      if (wr_t1 && SFR_ADDR_I == dtr_pkg::ADDR_T1H) begin
         th1_d = SFR_WDATA_I;
      end
   end

   // Control and mode registers; hardware flag set wins over any clear
   always_comb begin
      ctl_d  = ctl_q;
      mcfg_d = wr_tmc ? SFR_WDATA_I : mcfg_q;
      if (wr_tcs) begin
         ctl_d = SFR_WDATA_I;
      end
      if (bit_hit) begin
         ctl_d = BIT_VAL_I ? (ctl_d | bit_mask) : (ctl_d & ~bit_mask);
      end
      if (ovf0) begin
         ctl_d[dtr_pkg::T0_OVF] = 1'b1;
      end
      if (ovf1) begin
         ctl_d[dtr_pkg::T1_OVF] = 1'b1;
      end
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      rdata_d = SFR_RDATA_O;
      if (SFR_RD_I) begin
         unique case (SFR_ADDR_I)
            dtr_pkg::ADDR_TCS: rdata_d = ctl_q;
            dtr_pkg::ADDR_TMC: rdata_d = mcfg_q;
            dtr_pkg::ADDR_T0L: rdata_d = lo0_q;
            dtr_pkg::ADDR_T0H: rdata_d = hi0_q;
            dtr_pkg::ADDR_T1L: rdata_d = tl1_q;
            dtr_pkg::ADDR_T1H: rdata_d = th1_q;
            default:           rdata_d = dtr_pkg::RST_BYTE;
         endcase
      end
   end

   // State registers
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctl_q       <= dtr_pkg::RST_BYTE;
         mcfg_q      <= dtr_pkg::RST_BYTE;
         lo0_q       <= dtr_pkg::RST_BYTE;
         hi0_q       <= dtr_pkg::RST_BYTE;
         tl1_q       <= dtr_pkg::RST_BYTE;
         th1_q       <= dtr_pkg::RST_BYTE;
         SFR_RDATA_O <= dtr_pkg::RST_BYTE;
         div_q       <= 4'h0;
         cpin_prev_q <= 2'h0;
      end else begin
         ctl_q       <= ctl_d;
         mcfg_q      <= mcfg_d;
         lo0_q       <= lo0_d;
         hi0_q       <= hi0_d;
         tl1_q       <= tl1_d;
         th1_q       <= th1_d;
         SFR_RDATA_O <= rdata_d;
         div_q       <= div_d;
         cpin_prev_q <= cpin_prev_d;
      end
   end

   // Flag outputs
   assign T0_OVERFLOW_FLAG_O = ctl_q[dtr_pkg::T0_OVF];
   assign T1_OVERFLOW_FLAG_O = ctl_q[dtr_pkg::T1_OVF];

   // ==========================================================================
   // Checks
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);

   // Software clear of the timer 0 flag in this cycle
   logic clr0;
   assign clr0 = (wr_tcs && !SFR_WDATA_I[dtr_pkg::T0_OVF]) ||
                 (bit_hit && !BIT_VAL_I && bit_mask[dtr_pkg::T0_OVF]);

   sequence s_t1_wrap;
      en_t1 && !split && s1[16];
   endsequence
   sequence s_t0_wrap;
      en_t0 && s0[16];
   endsequence
   sequence s_tick_gap;
      (!tick)[*8] ##1 (!tick)[*3] ##1 tick;
   endsequence

   property p_t1_flag;
      s_t1_wrap |=> ctl_q[dtr_pkg::T1_OVF];
   endproperty
   a_t1_flag: assert property (p_t1_flag) else $error("timer 1 wrap left flag clear");

   property p_t1_hold;
      !ctl_q[dtr_pkg::T1_RUN] && !split && !wr_t1 |=> $stable(cnt1);
   endproperty
   a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved while stopped");

   property p_t0_flag;
      s_t0_wrap |=> ctl_q[dtr_pkg::T0_OVF];
   endproperty
   a_t0_flag: assert property (p_t0_flag) else $error("timer 0 wrap left flag clear");

   property p_t0_hold;
      !ctl_q[dtr_pkg::T0_RUN] && !split && !wr_t0 |=> $stable(cnt0);
   endproperty
   a_t0_hold: assert property (p_t0_hold) else $error("timer 0 moved while stopped");

   property p_bit_wr;
      bit_hit && !wr_tcs && !ovf0 && !ovf1 |=>
         ctl_q == (($past(ctl_q) & ~$past(bit_mask)) |
                    ($past(BIT_VAL_I) ? $past(bit_mask) : 8'h00));
   endproperty
   a_bit_wr: assert property (p_bit_wr) else $error("bit write disturbed other bits");

   property p_mode16;
      mcfg_q[3:0] == 4'h1 && ctl_q[dtr_pkg::T0_RUN] && tick && !wr_t0 |=>
         cnt0 == 16'($past(cnt0) + 16'h0001);
   endproperty
   a_mode16: assert property (p_mode16) else $error("16-bit step wrong");

   property p_tick;
      tick |=> s_tick_gap;
   endproperty
   a_tick: assert property (p_tick) else $error("instruction tick not every 12 clocks");

   property p_gate;
      mcfg_q[dtr_pkg::GATE_BIT] && !irq0_lvl && !split && !wr_t0 |=> $stable(cnt0);
   endproperty
   a_gate: assert property (p_gate) else $error("gated timer 0 ran with input low");

   property p_split8;
      split && en_t0 && (&lo0_q) && !wr_t0 |=> lo0_q == dtr_pkg::RST_BYTE;
   endproperty
   a_split8: assert property (p_split8) else $error("split low byte did not wrap");

   property p_sticky;
      ctl_q[dtr_pkg::T0_OVF] && !clr0 |=> ctl_q[dtr_pkg::T0_OVF];
   endproperty
   a_sticky: assert property (p_sticky) else $error("timer 0 flag dropped by itself");
endmodule
`default_nettype wire

/* hdl/dtr_pkg.sv */

// ==========================================================================
// Shared constants
package dtr_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] ADDR_TCS = 8'h88;
   localparam logic [7:0] ADDR_TMC = 8'h89;
   localparam logic [7:0] ADDR_T0L = 8'h8A;
   localparam logic [7:0] ADDR_T1L = 8'h8B;
   localparam logic [7:0] ADDR_T0H = 8'h8C;
   localparam logic [7:0] ADDR_T1H = 8'h8D;
   // Bit-address block of the control register (bit addresses 88h to 8Fh)
   localparam logic [4:0] BIT_BLOCK = 5'h11;
   // Control register bit positions
   localparam int T1_OVF = 7;
   localparam int T1_RUN = 6;
   localparam int T0_OVF = 5;
   localparam int T0_RUN = 4;
   // Mode nibble layout; timer 1 nibble sits four bits up
   localparam int GATE_BIT = 3;
   localparam int CT_BIT   = 2;
   localparam int T1_NIB   = 4;
   // Mode encodings
   localparam logic [1:0] MODE_13     = 2'h0;
   localparam logic [1:0] MODE_16     = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT  = 2'h3;
   // Oscillator periods per instruction cycle
   localparam logic [3:0] TICK_DIV  = 4'hC;
   localparam logic [3:0] TICK_LAST = TICK_DIV - 4'h1;
   // Reset value of every byte register
   localparam logic [7:0] RST_BYTE = 8'h00;

   // One count step: returns {wrap, high, low}
   function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] hi,
                                        input logic [7:0] lo);
      logic [16:0] r;
      logic [12:0] c13;
      logic [15:0] c16;
      r   = {1'b0, hi, lo};
      c13 = 13'({hi, lo[4:0]} + 13'h0001);
      c16 = 16'({hi, lo} + 16'h0001);
      case (mode)
         MODE_13:     r = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
         MODE_16:     r = {&{hi, lo}, c16};
         MODE_RELOAD: r = {&lo, hi, (&lo) ? hi : 8'(lo + 8'h01)};
         default:     r = {&lo, hi, 8'(lo + 8'h01)};
      endcase
      return r;
   endfunction
endpackage

/* hdl/dtr_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Pin synchroniser: three stages, level changes once stages two and three agree
module dtr_pin_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Pins and filtered levels
   input  wire logic [W-1:0] pin_i,
   output var  logic [W-1:0] level_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] level_d;

   // Take stage two where it agrees with stage three
   always_comb begin
      level_d = (s2_q & ~(s2_q ^ s3_q)) | (level_o & (s2_q ^ s3_q)); // Hold while stages differ
   end

   // Synchroniser chain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         level_o <= '0;
      end else begin
         s1_q    <= pin_i;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         level_o <= level_d;
      end
   end
endmodule
`default_nettype wire

/* test/dtr_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Outside world: gating pins and event pins of the timer block
module dtr_pin_model (
   // Levels asked for by the bench
   input  wire logic t0_pin_gate_enable_lvl_i,
   input  wire logic gate1_lvl_i,
   // Pins towards the block
   output wire logic irq0_o,
   output wire logic irq1_o,
   output wire logic cnt0_o,
   output wire logic cnt1_o
);
   // Gate pins follow off the clock grid, like a board trace
   assign #3.3 irq0_o = t0_pin_gate_enable_lvl_i;
   assign #4.7 irq1_o = gate1_lvl_i;
   // Event pins idle high, no events sent
   assign cnt0_o = 1'b1;
   assign cnt1_o = 1'b1;
endmodule
`default_nettype wire

/* test/dual_timer_run_overflow_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Bench for run control, overflow flags and gating of the dual timer
module dual_timer_run_overflow_control_bench;
   logic        clk, rst_n, wr, rd, bwr, bval, g0, g1;
   logic [7:0]  addr, wdata, baddr, rdata, nib, h, l, gh, gl, gv;
   logic [16:0] e;
   wire logic   irq0, irq1, cnt0, cnt1, f0, f1;
   integer      seed, mismatches, cmp_count;

   // Clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   dtr_timer_top dut (.CLOCK_I(clk), .RESETN_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
      .SFR_WDATA_I(wdata), .SFR_RD_I(rd), .SFR_RDATA_O(rdata), .BIT_WR_I(bwr),
      .BIT_ADDR_I(baddr), .BIT_VAL_I(bval), .EXT_IRQ0_INPUT_I(irq0), .EXT_IRQ1_INPUT_I(irq1),
      .T0_COUNT_PIN_I(cnt0), .T1_COUNT_PIN_I(cnt1), .T0_OVERFLOW_FLAG_O(f0),
      .T1_OVERFLOW_FLAG_O(f1));

   dtr_pin_model pins (.t0_pin_gate_enable_lvl_i(g0), .gate1_lvl_i(g1), .irq0_o(irq0), .irq1_o(irq1),
      .cnt0_o(cnt0), .cnt1_o(cnt1));

   // ==========================================================================
   // Bus tasks
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      d = rdata;
   endtask

   task automatic bw(input logic [7:0] a, input logic v);
      @(posedge clk);
      #1;
      baddr = a;
      bval = v;
      bwr = 1'b1;
      @(posedge clk);
      #1;
      bwr = 1'b0;
   endtask

   // Run bit high for exactly n edges
   task automatic run(input int t, input int n);
      bw(8'(8'h8C + 2 * t), 1'b1);
      repeat (n - 2) @(posedge clk);
      bw(8'(8'h8C + 2 * t), 1'b0);
   endtask

   // High, low, high again; retry while the highs differ
   task automatic rd_cnt(input int t, output logic [7:0] hi, output logic [7:0] lo);
      logic [7:0] h2;
      do begin
         rd8(8'(dtr_pkg::ADDR_T0H + t), hi);
         rd8(8'(dtr_pkg::ADDR_T0L + t), lo);
         rd8(8'(dtr_pkg::ADDR_T0H + t), h2);
      end while (h2 !== hi);
   endtask

   // ==========================================================================
   // Compares
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
      end
   endtask

   // Ten steps of a timer: {any wrap, high, low}
   function automatic logic [16:0] adv(input logic [1:0] m, input logic [7:0] hi,
                                       input logic [7:0] lo);
      logic [16:0] r;
      logic        w;
      r = {1'b0, hi, lo};
      w = 1'b0;
      repeat (10) begin
         case (m)
            2'h0: {r[16], r[15:8], r[4:0]} = {1'b0, r[15:8], r[4:0]} + 14'h0001;
            2'h1: r = {1'b0, r[15:0]} + 17'h0_0001;
            2'h2: r = (&r[7:0]) ? {1'b1, r[15:8], r[15:8]} : {1'b0, r[15:0]} + 17'h0_0001;
            default: r[16] = 1'b0;
         endcase
         w = w | r[16];
      end
      return {w, r[15:0]};
   endfunction

   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("[ERR] %0t run timed out", $time);
      test_done;
   end

   // ==========================================================================
   // Main sequence
   initial begin
      seed = 32'h0ed9_cdbd;
      mismatches = 0;
      cmp_count = 0;
      {rst_n, wr, rd, bwr, bval, g0, g1} = 7'h00;
      {addr, wdata, baddr} = 24'h00_0000;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // Reset values of every byte register and both flags
      for (int a = 8'h88; a <= 8'h8D; a++) begin
         rd8(8'(a), gv);
         chk8(gv, 8'h00);
      end
      chk1(f0, 1'b0);
      chk1(f1, 1'b0);
      $display("test reset done");
      // Both timers in every mode except split on timer 0, random and near-top starts, stop and resume
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
               if (t == 0 && m == 3) continue;
               nib = 8'($random(seed));
               h = k ? 8'hFF : 8'($random(seed));
               l = k ? 8'hF8 : 8'($random(seed));
               g0 = 1'($random(seed));
               wr8(dtr_pkg::ADDR_TCS, {4'h0, nib[3:0]});
               wr8(dtr_pkg::ADDR_TMC, 8'(m << (4 * t)));
               wr8(8'(dtr_pkg::ADDR_T0L + t), l);
               wr8(8'(dtr_pkg::ADDR_T0H + t), h);
               run(t, 60);
               repeat (30) @(posedge clk);
               run(t, 60);
               repeat (30) @(posedge clk);
               e = adv(2'(m), h, l);
               rd_cnt(t, gh, gl);
               chk8(gh, e[15:8]);
               chk8(gl, e[7:0]);
               chk1(t ? f1 : f0, e[16]);
               rd8(dtr_pkg::ADDR_TCS, gv);
               chk8(gv, {t == 1 && e[16], 1'b0, t == 0 && e[16], 1'b0, nib[3:0]});
               bw(8'(8'h8D + 2 * t), 1'b0);
               @(posedge clk);
               chk1(t ? f1 : f0, 1'b0);
            end
         end
      end
      $display("test modes done");
      // Gated timer 0: pin low holds it, pin high lets it count
      wr8(dtr_pkg::ADDR_TMC, 8'h09);
      wr8(dtr_pkg::ADDR_T0L, 8'h00);
      wr8(dtr_pkg::ADDR_T0H, 8'h00);
      for (int k = 0; k < 2; k++) begin
         g0 = k[0];
         repeat (8) @(posedge clk);
         run(0, 120);
         rd_cnt(0, gh, gl);
         chk8(gl, k ? 8'h0A : 8'h00);
         chk8(gh, 8'h00);
      end
      $display("test gate done");
      // Split timer 0: low byte on its own run bit, high byte on timer 1 run bit
      wr8(dtr_pkg::ADDR_TMC, 8'h03);
      wr8(dtr_pkg::ADDR_T0L, 8'hFE);
      wr8(dtr_pkg::ADDR_T0H, 8'hFD);
      wr8(dtr_pkg::ADDR_TCS, 8'h50);
      repeat (58) @(posedge clk);
      chk1(f0, 1'b1);
      chk1(f1, 1'b1);
      wr8(dtr_pkg::ADDR_TCS, 8'h00);
      rd8(dtr_pkg::ADDR_T0L, gv);
      chk8(gv, 8'h03);
      rd8(dtr_pkg::ADDR_T0H, gv);
      chk8(gv, 8'h02);
      $display("test split done");
      // Free-running 16-bit timer 0 wraps, then software sets timer 1 flag
      wr8(dtr_pkg::ADDR_TCS, 8'h00);
      wr8(dtr_pkg::ADDR_TMC, 8'h01);
      wr8(dtr_pkg::ADDR_T0H, 8'hFF);
      wr8(dtr_pkg::ADDR_T0L, 8'hFF);
      bw(8'h8C, 1'b1);
      for (int i = 0; i < 30 && f0 !== 1'b1; i++) @(posedge clk);
      chk1(f0, 1'b1);
      bw(8'h8C, 1'b0);
      bw(8'h8F, 1'b1);
      rd8(dtr_pkg::ADDR_TCS, gv);
      chk8(gv, 8'hA0);
      chk1(f1, 1'b1);
      $display("test wrap done");
      test_done;
   end
endmodule
`default_nettype wire
